// file: bench/sws_engine_model.sv
`timescale 1ns/1ps
module sws_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench requests: bit 2 wakeup start, bit 1 cycle start, bit 0 macrotick
  input wire sws_pkg::sws_engine_state_t state_req,
  input wire logic [2:0] ev_req,
  // Engine side of the block
  output sws_pkg::sws_engine_state_t engine_state,
  output sws_pkg::sws_events_t engine_events
);
  logic [1:0] bit_div_ff;
  // Bit ticks run free so a wakeup always advances; a real line is much slower.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_div_ff <= 2'h0;
      engine_state <= sws_pkg::ENG_CONFIG;
      engine_events <= '0;
    end else begin
      bit_div_ff <= bit_div_ff + 2'h1;
      engine_state <= state_req;
      engine_events <= {ev_req[1], ev_req[0], bit_div_ff == 2'h3, ev_req[2]};
    end
  end
endmodule : sws_engine_model

// file: bench/sws_regs_props.sv
`timescale 1ns/1ps
module sws_regs_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // Engine side
  input wire logic line_a_symbol_enable, line_b_symbol_enable,
  input wire logic [4:0] listen_noise_cycles,
  input wire logic wakeup_low_a, wakeup_low_b
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before it was taken");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // The response flop is set one edge after both halves are held, so it shows two edges on.
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write taken while a response is pending");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  enable_hold_a: assert property (
    !$rose(s_axi_bvalid) |=> $stable({line_b_symbol_enable, line_a_symbol_enable}))
    else $error("symbol enable moved without a write");
  noise_hold_a: assert property (!$rose(s_axi_bvalid) |=> $stable(listen_noise_cycles))
    else $error("listen timeout moved without a write");

  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property ($rose(wakeup_low_a));
  cover property ($rose(wakeup_low_b));
endmodule : sws_regs_props

// file: bench/test_symbol_wakeup_status_regs.sv
`timescale 1ns/1ps
module test_symbol_wakeup_status_regs;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic line_a_symbol_enable, line_b_symbol_enable, wakeup_low_a, wakeup_low_b, wakeup_busy;
  logic [4:0] listen_noise_cycles;
  sws_pkg::sws_engine_state_t engine_state;
  sws_pkg::sws_events_t engine_events;
  sws_pkg::sws_engine_state_t state_req = sws_pkg::ENG_CONFIG;
  logic [2:0] ev_req = 3'h0;
  int n_errors = 0;
  int comparisons = 0;
  // Byte addresses and writable bits; the first three are status registers.
  localparam logic [11:0] ADDR [8] = '{12'h020, 12'h028, 12'h030, 12'h210, 12'h228,
    12'h358, 12'h3a8, 12'h3b0};
  localparam logic [15:0] MASK [8] = '{16'h0, 16'h0, 16'h0, 16'h0060, 16'h007f,
    16'h001f, 16'h00ff, 16'h003f};
  logic [15:0] mdl [8];

  always #2 aclk = ~aclk;

  sws_regs i_dut (.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .*);
  sws_engine_model i_eng (.aclk(aclk), .aresetn(aresetn), .state_req(state_req),
    .ev_req(ev_req), .engine_state(engine_state), .engine_events(engine_events));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Ready is looked at on the falling edge, where it already shows the next sample.
  task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      if (s_axi_awready === 1'b1) pa = 1'b0;
      if (s_axi_wready === 1'b1) pw = 1'b0;
      @(posedge aclk);
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask : rd

  task automatic rchk(input int i);
    logic [31:0] d;
    logic [1:0] r;
    rd(ADDR[i], d, r);
    check("rdata", d, {16'h0000, mdl[i]});
    check("rresp", r, 2'b00);
  endtask : rchk

  task automatic ev(input logic [2:0] k, input int n);
    repeat (n) begin
      ev_req <= k;
      @(posedge aclk);
      ev_req <= 3'h0;
      @(posedge aclk);
    end
  endtask : ev

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  initial begin
    int i, k, na, nb;
    logic [31:0] d;
    logic [1:0] r, pv;
    logic [15:0] v;
    void'($urandom(32'h56ed1dad));
    for (i = 0; i < 8; i++) mdl[i] = 16'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 8; i++) rchk(i);
    for (i = 0; i < 8; i++) begin
      v = $urandom;
      wr(ADDR[i], v, r);
      check("bresp", r, (i < 3) ? 2'b10 : 2'b00);
      if (i > 2) mdl[i] = v & MASK[i];
      rchk(i);
    end
    @(negedge aclk);
    check("line a", line_a_symbol_enable, mdl[3][5]);
    check("line b", line_b_symbol_enable, mdl[3][6]);
    check("noise", listen_noise_cycles, mdl[5][4:0]);
    @(posedge aclk);
    wr(12'h024, 16'hffff, r);
    check("bresp", r, 2'b10);
    rd(12'h211, d, r);
    check("rdata", d, 32'h0);
    check("rresp", r, 2'b10);
    s_axi_wstrb <= 4'h0;
    wr(ADDR[3], ~mdl[3], r);
    s_axi_wstrb <= 4'hf;
    check("bresp", r, 2'b00);
    rchk(3);
    for (i = 1; i < 6; i++) begin
      state_req <= sws_pkg::sws_engine_state_t'(i);
      repeat (3) @(posedge aclk);
      mdl[2] = i;
      rchk(2);
    end
    state_req <= sws_pkg::ENG_NORMAL_ACTIVE;
    repeat (3) @(posedge aclk);
    mdl[2] = 16'h0002;
    for (i = 4; i < 8; i++) begin
      wr(ADDR[i], ~mdl[i], r);
      check("bresp", r, 2'b10);
      rchk(i);
    end
    v = ~mdl[3];
    wr(ADDR[3], v, r);
    check("bresp", r, 2'b00);
    mdl[3] = v & MASK[3];
    rchk(3);
    ev(3'b010, 65);
    ev(3'b001, 7);
    mdl[0] = 16'd7;
    mdl[1] = 16'd65 % 16'd64;
    rchk(0);
    rchk(1);
    ev(3'b010, 1);
    mdl[0] = 16'h0;
    mdl[1] = 16'd2;
    rchk(0);
    rchk(1);
    ev(3'b001, 3);
    state_req <= sws_pkg::ENG_CONFIG;
    repeat (3) @(posedge aclk);
    state_req <= sws_pkg::ENG_INIT_SCHEDULE;
    repeat (3) @(posedge aclk);
    mdl[1] = 16'h0;
    rchk(0);
    rchk(1);
    state_req <= sws_pkg::ENG_CONFIG;
    repeat (3) @(posedge aclk);
    wr(ADDR[6], 16'h0001, r);
    wr(ADDR[7], 16'h0002, r);
    for (k = 0; k < 2; k++) begin
      wr(ADDR[4], k ? 16'h0043 : 16'h0020, r);
      ev(3'b100, 1);
      na = 0;
      nb = 0;
      pv = 2'b00;
      repeat (400) begin
        @(negedge aclk);
        if (wakeup_low_a === 1'b1 && !pv[0]) na++;
        if (wakeup_low_b === 1'b1 && !pv[1]) nb++;
        pv = {wakeup_low_b === 1'b1, wakeup_low_a === 1'b1};
      end
      check("wake a", na, k ? 0 : 2);
      check("wake b", nb, k ? 3 : 0);
      check("busy", wakeup_busy, 1'b0);
      @(posedge aclk);
    end
    complete_run();
  end
endmodule : test_symbol_wakeup_status_regs

bind sws_regs sws_regs_props i_props (.*);

// file: logic/sws_cycle_counter.sv
`timescale 1ns/1ps
module sws_cycle_counter #(
  parameter int NUMBER_W = sws_pkg::CYCLE_NUMBER_W,
  parameter int TIME_W = sws_pkg::CYCLE_TIME_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Engine timing
  input wire logic clear,
  input wire logic cycle_start,
  input wire logic macrotick,
  // Counts
  output logic [NUMBER_W-1:0] cycle_number,
  output logic [TIME_W-1:0] cycle_time
);

  logic [NUMBER_W-1:0] number_ff;
  logic [TIME_W-1:0] time_ff;
  logic [NUMBER_W-1:0] nxt_number;
  logic [TIME_W-1:0] nxt_time;

  // Natural overflow gives the wrap to zero at the maximum.
  assign nxt_number = clear ? '0 : (cycle_start ? number_ff + 1'b1 : number_ff);
  assign nxt_time = (clear || cycle_start) ? '0 :
                    (macrotick ? time_ff + 1'b1 : time_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      number_ff <= '0;
      time_ff <= '0;
    end else begin
      number_ff <= nxt_number;
      time_ff <= nxt_time;
    end
  end

  assign cycle_number = number_ff;
  assign cycle_time = time_ff;

endmodule : sws_cycle_counter

// file: logic/sws_pkg.sv
// Behaviour
// - Bits 6 and 5 of the symbol window control register enable symbol sending on line B and A.
// - The symbol window control register takes host writes in configuration and in normal run.
// - Bits 6 and 5 of the wakeup control register enable wakeup symbols on line B and A.
// - The 5-bit repeat count sets the number of wakeup symbols, and never fewer than two go out.
// - Wakeup control, idle, low and listen-noise registers change only in configuration state.
// - The 8-bit idle duration sets the idle phase of each wakeup symbol in bit durations.
// - The 6-bit low duration sets the low phase of each wakeup symbol in bit durations.
// - The 5-bit listen-noise field sets the listen timeout with noise in communication cycles.
// - The protocol state register is read-only, holds a 5-bit code and clears on hard reset.
// - Codes are 0 configuration, 1 init schedule, 2 normal active, 3 normal passive, 4 consistency, 5 listen.
// - The cycle number clears on hard reset and when configuration state is left.
// - The cycle number advances once per cycle and wraps to zero at its maximum.
// - The 14-bit cycle time clears on hard reset and when configuration state is left.
// - The cycle time counts macroticks and returns to zero at the start of each cycle.
package sws_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] IDX_CYCLE_TIME = 10'h008;
  localparam logic [9:0] IDX_CYCLE_NUMBER = 10'h00a;
  localparam logic [9:0] IDX_PROTOCOL_STATE = 10'h00c;
  localparam logic [9:0] IDX_SYMBOL_WINDOW = 10'h084;
  localparam logic [9:0] IDX_WAKEUP_CONTROL = 10'h08a;
  localparam logic [9:0] IDX_LISTEN_NOISE = 10'h0d6;
  localparam logic [9:0] IDX_WAKEUP_IDLE = 10'h0ea;
  localparam logic [9:0] IDX_WAKEUP_LOW = 10'h0ec;

  // Field positions and widths.
  localparam int LINE_A_BIT = 5;
  localparam int LINE_B_BIT = 6;
  localparam int REPEAT_W = 5;
  localparam int IDLE_W = 8;
  localparam int LOW_W = 6;
  localparam int NOISE_W = 5;
  localparam int STATE_W = 5;
  localparam int CYCLE_NUMBER_W = 6;
  localparam int CYCLE_TIME_W = 14;

  // Writable bits of each register; every other bit is reserved.
  localparam logic [15:0] SYMBOL_WINDOW_MASK = 16'h0060;
  localparam logic [15:0] WAKEUP_CONTROL_MASK = 16'h007f;
  localparam logic [15:0] WAKEUP_IDLE_MASK = 16'h00ff;
  localparam logic [15:0] WAKEUP_LOW_MASK = 16'h003f;
  localparam logic [15:0] LISTEN_NOISE_MASK = 16'h001f;

  // Reset values.
  localparam logic [15:0] SYMBOL_WINDOW_RESET = 16'h0000;
  localparam logic [15:0] WAKEUP_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] WAKEUP_IDLE_RESET = 16'h0000;
  localparam logic [15:0] WAKEUP_LOW_RESET = 16'h0000;
  localparam logic [15:0] LISTEN_NOISE_RESET = 16'h0000;
  localparam logic [STATE_W-1:0] STATE_CODE_RESET = 5'h00;

  // Protocol state codes shown to the host.
  localparam logic [STATE_W-1:0] CODE_CONFIG = 5'h00;
  localparam logic [STATE_W-1:0] CODE_INIT_SCHEDULE = 5'h01;
  localparam logic [STATE_W-1:0] CODE_NORMAL_ACTIVE = 5'h02;
  localparam logic [STATE_W-1:0] CODE_NORMAL_PASSIVE = 5'h03;
  localparam logic [STATE_W-1:0] CODE_INTEG_CHECK = 5'h04;
  localparam logic [STATE_W-1:0] CODE_INTEG_LISTEN = 5'h05;

  localparam logic [REPEAT_W-1:0] MIN_WAKEUP_SYMBOLS = 5'h02;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    ENG_CONFIG,
    ENG_INIT_SCHEDULE,
    ENG_NORMAL_ACTIVE,
    ENG_NORMAL_PASSIVE,
    ENG_INTEG_CHECK,
    ENG_INTEG_LISTEN
  } sws_engine_state_t;

  // Timing events from the protocol engine, all one-cycle pulses on aclk.
  typedef struct packed {
    logic cycle_start;
    logic macrotick;
    logic bit_tick;
    logic wakeup_start;
  } sws_events_t;

  // Phase lengths of zero would wrap the bit counter and stretch the phase to 256 bits, so they count as one bit.
  function automatic logic [7:0] sws_at_least(input logic [7:0] value, input logic [7:0] floor);
    sws_at_least = (value < floor) ? floor : value;
  endfunction : sws_at_least

endpackage : sws_pkg

// file: logic/sws_regs.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sws_regs (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Protocol engine status and timing
  input wire sws_pkg::sws_engine_state_t engine_state,
  input wire sws_pkg::sws_events_t engine_events,
  // Configuration toward the engine
  output logic line_a_symbol_enable,
  output logic line_b_symbol_enable,
  output logic [sws_pkg::NOISE_W-1:0] listen_noise_cycles,
  // Wakeup line drive
  output logic wakeup_low_a,
  output logic wakeup_low_b,
  output logic wakeup_busy
);

  // Configuration registers, held at full width and masked on write.
  logic [15:0] symbol_window_control_ff;
  logic [15:0] wakeup_control_ff;
  logic [15:0] wakeup_idle_duration_ff;
  logic [15:0] wakeup_low_duration_ff;
  logic [15:0] listen_noise_timeout_ff;

  // Status.
  logic [sws_pkg::STATE_W-1:0] protocol_state_code_ff;
  logic was_config_ff;

  // Bus slave state.
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  logic [11:0] waddr_ff;
  logic [15:0] wdata_ff;
  logic wlane_ff;
  logic aw_held_ff;
  logic w_held_ff;

  // Outputs kept in flops.
  logic sym_a_ff;
  logic sym_b_ff;
  logic [sws_pkg::NOISE_W-1:0] noise_ff;

  // Counter and sequencer results.
  logic [sws_pkg::CYCLE_NUMBER_W-1:0] cycle_number;
  logic [sws_pkg::CYCLE_TIME_W-1:0] cycle_time_ticks;
  logic seq_low_a;
  logic seq_low_b;
  logic seq_busy;
  logic seq_low_a_ff;
  logic seq_low_b_ff;
  logic seq_busy_ff;

  // Maps a bus byte address onto a register index; misaligned words miss.
  function automatic logic [9:0] reg_index(input logic [11:0] addr);
    reg_index = (addr[1:0] == 2'b00) ? addr[11:2] : 10'h3ff;
  endfunction : reg_index

  // Write-mask merge: reserved bits stay zero whatever the host writes.
  function automatic logic [15:0] merge(input logic [15:0] data, input logic [15:0] mask);
    merge = data & mask;
  endfunction : merge

  // Decode.
  wire in_config = (engine_state == sws_pkg::ENG_CONFIG);
  wire leaving_config = was_config_ff && !in_config;
  wire aw_take = s_axi_awvalid && awready_ff;
  wire w_take = s_axi_wvalid && wready_ff;
  wire ar_take = s_axi_arvalid && arready_ff;
  wire write_now = aw_held_ff && w_held_ff && !bvalid_ff;
  wire [9:0] widx = reg_index(waddr_ff);
  wire [9:0] ridx = reg_index(s_axi_araddr);

  wire hit_sym = (widx == sws_pkg::IDX_SYMBOL_WINDOW);
  wire hit_wake = (widx == sws_pkg::IDX_WAKEUP_CONTROL);
  wire hit_idle = (widx == sws_pkg::IDX_WAKEUP_IDLE);
  wire hit_low = (widx == sws_pkg::IDX_WAKEUP_LOW);
  wire hit_noise = (widx == sws_pkg::IDX_LISTEN_NOISE);
  wire hit_status = (widx == sws_pkg::IDX_CYCLE_TIME) ||
                    (widx == sws_pkg::IDX_CYCLE_NUMBER) ||
                    (widx == sws_pkg::IDX_PROTOCOL_STATE);
  wire hit_cfg_only = hit_wake || hit_idle || hit_low || hit_noise;

  // The symbol window register is open in every state; the rest only in configuration.
  wire wr_sym = write_now && hit_sym && wlane_ff;
  wire wr_cfg_ok = write_now && in_config && wlane_ff;
  wire wr_wake = wr_cfg_ok && hit_wake;
  wire wr_idle = wr_cfg_ok && hit_idle;
  wire wr_low = wr_cfg_ok && hit_low;
  wire wr_noise = wr_cfg_ok && hit_noise;

  // Writes to status registers, locked registers or holes are refused with SLVERR.
  wire wr_refused = !(hit_sym || (hit_cfg_only && in_config)) || hit_status;
  wire [1:0] nxt_bresp = wr_refused ? sws_pkg::RESP_SLVERR : sws_pkg::RESP_OKAY;

  // Read selection.
  logic [15:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    case (ridx)
      sws_pkg::IDX_CYCLE_TIME: rd_word = {2'b00, cycle_time_ticks};
      sws_pkg::IDX_CYCLE_NUMBER: rd_word = {10'h000, cycle_number};
      sws_pkg::IDX_PROTOCOL_STATE: rd_word = {11'h000, protocol_state_code_ff};
      sws_pkg::IDX_SYMBOL_WINDOW: rd_word = symbol_window_control_ff;
      sws_pkg::IDX_WAKEUP_CONTROL: rd_word = wakeup_control_ff;
      sws_pkg::IDX_LISTEN_NOISE: rd_word = listen_noise_timeout_ff;
      sws_pkg::IDX_WAKEUP_IDLE: rd_word = wakeup_idle_duration_ff;
      sws_pkg::IDX_WAKEUP_LOW: rd_word = wakeup_low_duration_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  // Protocol state code shown to the host.
  logic [sws_pkg::STATE_W-1:0] nxt_state_code;
  always_comb begin
    case (engine_state)
      sws_pkg::ENG_CONFIG: nxt_state_code = sws_pkg::CODE_CONFIG;
      sws_pkg::ENG_INIT_SCHEDULE: nxt_state_code = sws_pkg::CODE_INIT_SCHEDULE;
      sws_pkg::ENG_NORMAL_ACTIVE: nxt_state_code = sws_pkg::CODE_NORMAL_ACTIVE;
      sws_pkg::ENG_NORMAL_PASSIVE: nxt_state_code = sws_pkg::CODE_NORMAL_PASSIVE;
      sws_pkg::ENG_INTEG_CHECK: nxt_state_code = sws_pkg::CODE_INTEG_CHECK;
      sws_pkg::ENG_INTEG_LISTEN: nxt_state_code = sws_pkg::CODE_INTEG_LISTEN;
      default: nxt_state_code = sws_pkg::CODE_CONFIG;
    endcase
  end

  // Write address and data channels, taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
      waddr_ff <= 12'h000;
    end else if (aw_take) begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b1;
      waddr_ff <= s_axi_awaddr;
    end else if (bvalid_ff && s_axi_bready) begin
      awready_ff <= 1'b1;
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b1;
      w_held_ff <= 1'b0;
      wdata_ff <= 16'h0000;
      wlane_ff <= 1'b0;
    end else if (w_take) begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata[15:0];
      wlane_ff <= s_axi_wstrb[0];
    end else if (bvalid_ff && s_axi_bready) begin
      wready_ff <= 1'b1;
      w_held_ff <= 1'b0;
    end
  end

  // Write response follows both halves by one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= sws_pkg::RESP_OKAY;
    end else if (write_now) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= nxt_bresp;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel: one read outstanding, data one cycle after the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= sws_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (ar_take) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= rd_hit ? sws_pkg::RESP_OKAY : sws_pkg::RESP_SLVERR;
      rdata_ff <= {16'h0000, rd_word};
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // Configuration registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      symbol_window_control_ff <= sws_pkg::SYMBOL_WINDOW_RESET;
    end else if (wr_sym) begin
      symbol_window_control_ff <= merge(wdata_ff, sws_pkg::SYMBOL_WINDOW_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wakeup_control_ff <= sws_pkg::WAKEUP_CONTROL_RESET;
      wakeup_idle_duration_ff <= sws_pkg::WAKEUP_IDLE_RESET;
      wakeup_low_duration_ff <= sws_pkg::WAKEUP_LOW_RESET;
      listen_noise_timeout_ff <= sws_pkg::LISTEN_NOISE_RESET;
    end else begin
      if (wr_wake) begin
        wakeup_control_ff <= merge(wdata_ff, sws_pkg::WAKEUP_CONTROL_MASK);
      end
      if (wr_idle) begin
        wakeup_idle_duration_ff <= merge(wdata_ff, sws_pkg::WAKEUP_IDLE_MASK);
      end
      if (wr_low) begin
        wakeup_low_duration_ff <= merge(wdata_ff, sws_pkg::WAKEUP_LOW_MASK);
      end
      if (wr_noise) begin
        listen_noise_timeout_ff <= merge(wdata_ff, sws_pkg::LISTEN_NOISE_MASK);
      end
    end
  end

  // Status and output flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protocol_state_code_ff <= sws_pkg::STATE_CODE_RESET;
      was_config_ff <= 1'b1;
      sym_a_ff <= 1'b0;
      sym_b_ff <= 1'b0;
      noise_ff <= '0;
    end else begin
      protocol_state_code_ff <= nxt_state_code;
      was_config_ff <= in_config;
      sym_a_ff <= symbol_window_control_ff[sws_pkg::LINE_A_BIT];
      sym_b_ff <= symbol_window_control_ff[sws_pkg::LINE_B_BIT];
      noise_ff <= listen_noise_timeout_ff[sws_pkg::NOISE_W-1:0];
    end
  end

  // Keeps wakeup line outputs on flops of this module.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_low_a_ff <= 1'b0;
      seq_low_b_ff <= 1'b0;
      seq_busy_ff <= 1'b0;
    end else begin
      seq_low_a_ff <= seq_low_a;
      seq_low_b_ff <= seq_low_b;
      seq_busy_ff <= seq_busy;
    end
  end

  sws_cycle_counter #(
    .NUMBER_W(sws_pkg::CYCLE_NUMBER_W),
    .TIME_W(sws_pkg::CYCLE_TIME_W)
  ) u_cycle_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(leaving_config),
    .cycle_start(engine_events.cycle_start),
    .macrotick(engine_events.macrotick),
    .cycle_number(cycle_number),
    .cycle_time(cycle_time_ticks)
  );

  // The sequencer only runs on request from the engine and reads the latched setup.
  sws_wakeup_sequencer u_wakeup_sequencer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(engine_events.wakeup_start),
    .bit_tick(engine_events.bit_tick),
    .enable_a(wakeup_control_ff[sws_pkg::LINE_A_BIT]),
    .enable_b(wakeup_control_ff[sws_pkg::LINE_B_BIT]),
    .repeat_count(wakeup_control_ff[sws_pkg::REPEAT_W-1:0]),
    .idle_bits(wakeup_idle_duration_ff[sws_pkg::IDLE_W-1:0]),
    .low_bits(wakeup_low_duration_ff[sws_pkg::LOW_W-1:0]),
    .tx_low_a(seq_low_a),
    .tx_low_b(seq_low_b),
    .busy(seq_busy)
  );

  // Bus outputs.
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Engine-facing outputs.
  assign line_a_symbol_enable = sym_a_ff;
  assign line_b_symbol_enable = sym_b_ff;
  assign listen_noise_cycles = noise_ff;
  assign wakeup_low_a = seq_low_a_ff;
  assign wakeup_low_b = seq_low_b_ff;
  assign wakeup_busy = seq_busy_ff;

endmodule : sws_regs

// file: logic/sws_wakeup_sequencer.sv
`timescale 1ns/1ps
module sws_wakeup_sequencer (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  input wire logic bit_tick,
  input wire logic enable_a,
  input wire logic enable_b,
  input wire logic [sws_pkg::REPEAT_W-1:0] repeat_count,
  input wire logic [sws_pkg::IDLE_W-1:0] idle_bits,
  input wire logic [sws_pkg::LOW_W-1:0] low_bits,
  // Line drive
  output logic tx_low_a,
  output logic tx_low_b,
  output logic busy
);

  typedef enum logic [1:0] {WS_IDLE, WS_LOW, WS_GAP} sws_wake_state_t;

  sws_wake_state_t state_ff;
  logic [7:0] bits_ff;
  logic [sws_pkg::REPEAT_W-1:0] left_ff;
  logic tx_a_ff;
  logic tx_b_ff;
  logic [sws_pkg::REPEAT_W-1:0] symbols;
  logic [7:0] low_len;
  logic [7:0] idle_len;
  logic phase_done;

  assign symbols = (repeat_count < sws_pkg::MIN_WAKEUP_SYMBOLS) ?
                   sws_pkg::MIN_WAKEUP_SYMBOLS : repeat_count;
  assign low_len = sws_pkg::sws_at_least({2'b00, low_bits}, 8'h01);
  assign idle_len = sws_pkg::sws_at_least(idle_bits, 8'h01);
  assign phase_done = bit_tick && (bits_ff == 8'h01);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= WS_IDLE;
      bits_ff <= 8'h00;
      left_ff <= '0;
      tx_a_ff <= 1'b0;
      tx_b_ff <= 1'b0;
    end else begin
      case (state_ff)
        WS_IDLE: begin
          if (start && (enable_a || enable_b)) begin
            state_ff <= WS_LOW;
            bits_ff <= low_len;
            left_ff <= symbols;
            tx_a_ff <= enable_a;
            tx_b_ff <= enable_b;
          end
        end
        WS_LOW: begin
          if (bit_tick) begin
            bits_ff <= bits_ff - 8'h01;
          end
          if (phase_done) begin
            state_ff <= WS_GAP;
            bits_ff <= idle_len;
            left_ff <= left_ff - 1'b1;
          end
        end
        WS_GAP: begin
          if (bit_tick) begin
            bits_ff <= bits_ff - 8'h01;
          end
          if (phase_done) begin
            if (left_ff == '0) begin
              state_ff <= WS_IDLE;
              tx_a_ff <= 1'b0;
              tx_b_ff <= 1'b0;
            end else begin
              state_ff <= WS_LOW;
              bits_ff <= low_len;
            end
          end
        end
        default: begin
          state_ff <= WS_IDLE;
        end
      endcase
    end
  end

  assign tx_low_a = tx_a_ff && (state_ff == WS_LOW);
  assign tx_low_b = tx_b_ff && (state_ff == WS_LOW);
  assign busy = (state_ff != WS_IDLE);

endmodule : sws_wakeup_sequencer
